/* dv/sdr_chk.sv */
// Port-level checker for the serializer, deserializer and register bus
`timescale 1ns/1ps
`default_nettype none
module sdr_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic tx_driver_enable,
  input wire logic power_down_n,
  input wire logic tx_serial_p_o,
  input wire logic tx_serial_n_o,
  input wire logic tx_serial_oe,
  input wire logic rx_output_enable,
  input wire logic rx_parallel_oe,
  input wire logic rx_not_aligned,
  input wire logic rx_not_aligned_oe,
  input wire logic rx_recovered_clock_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Four cycles cover the two-flop input synchroniser; the synchronised enables gate the outputs with no further register
  property p_den_off; !tx_driver_enable [*4] |-> !tx_serial_oe; endproperty
  a_den_off: assert property (p_den_off) else $error("pair driven with enable low");
  property p_pwr_off; !power_down_n [*4] |-> !tx_serial_oe; endproperty
  a_pwr_off: assert property (p_pwr_off) else $error("pair driven in powerdown");
  property p_pwr_init; $rose(power_down_n) |-> !tx_serial_oe [*8]; endproperty
  a_pwr_init: assert property (p_pwr_init) else $error("pair driven during init");
  property p_pair; tx_serial_oe |-> (tx_serial_n_o == !tx_serial_p_o); endproperty
  a_pair: assert property (p_pair) else $error("serial pair not complementary");
  property p_rx_valid; rx_parallel_oe |-> !rx_not_aligned; endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("word driven while unlocked");
  property p_rx_en;
    !rx_output_enable [*4] |-> !rx_parallel_oe && !rx_not_aligned_oe && !rx_recovered_clock_oe;
  endproperty
  a_rx_en: assert property (p_rx_en) else $error("receive outputs driven when disabled");
  property p_loss; $rose(rx_not_aligned) |-> !rx_parallel_oe && !rx_recovered_clock_oe; endproperty
  a_loss: assert property (p_loss) else $error("outputs driven after lock loss");
  property p_rst_flag; $fell(sys_rst) |-> rx_not_aligned ##1 rx_not_aligned; endproperty
  a_rst_flag: assert property (p_rst_flag) else $error("flag low right after reset");
  property p_wait;
    ($rose(avs_read) || $rose(avs_write)) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
endmodule // sdr_chk
bind sdr_top sdr_chk u_chk (.clock, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
  .tx_driver_enable, .power_down_n, .tx_serial_p_o, .tx_serial_n_o, .tx_serial_oe,
  .rx_output_enable, .rx_parallel_oe, .rx_not_aligned, .rx_not_aligned_oe,
  .rx_recovered_clock_oe);
`default_nettype wire

/* dv/sdr_far_end.sv */
// Far-end serializer model feeding the receive serial input
`timescale 1ns/1ps
`default_nettype none
module sdr_far_end (
  input  wire logic       clock,
  input  wire logic [1:0] mode,
  input  wire logic [9:0] word,
  output var  logic       serial
);
  logic [11:0] frame_q = 12'h000;
  logic [3:0]  cnt_q   = 4'h0;
  always @(posedge clock) begin
    cnt_q <= (cnt_q == 4'hB) ? 4'h0 : cnt_q + 4'h1;
    if (cnt_q == 4'hB) begin
      case (mode)
        2'h1:    frame_q <= 12'h03F;
        2'h2:    frame_q <= {1'b0, word, 1'b1};
        // Stop bit high: a deliberately broken frame
        default: frame_q <= {1'b1, word, 1'b1};
      endcase
    end
  end
  // Idle link rests low so the receiver sees no transitions
  assign serial = (mode == 2'h0) ? 1'b0 : frame_q[cnt_q];
endmodule // sdr_far_end
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the embedded-clock serializer and deserializer
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defines.vh"
module tb_top;
  localparam int TXI = 8;
  logic        clock = 1'b0, sys_rst = 1'b1, tx_word_clock = 1'b0, rx_reference_clock = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic        avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest;
  logic [9:0]  tx_parallel_in = 10'h000, rx_parallel_out, far_word = 10'h000;
  logic        tx_edge_select = 1'b1, tx_driver_enable = 1'b1, power_down_n = 1'b1;
  logic        align_request_a = 1'b0, align_request_b = 1'b0;
  logic        tx_serial_p_o, tx_serial_n_o, tx_serial_oe, rx_serial_in;
  logic        rx_power_down_n = 1'b1, rx_output_enable = 1'b1, rx_edge_select = 1'b0;
  logic        rx_parallel_oe, rx_not_aligned, rx_not_aligned_oe;
  logic        rx_recovered_clock, rx_recovered_clock_oe;
  logic [1:0]  far_mode = 2'h0;
  int          n_errors = 0, num_checks = 0;

  sdr_top #(.TX_INIT_EDGES(11'h008), .REF_EDGES(11'h002)) u_dut (.clock, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .tx_word_clock, .tx_parallel_in, .tx_edge_select, .tx_driver_enable, .power_down_n,
    .align_request_a, .align_request_b, .tx_serial_p_o, .tx_serial_n_o, .tx_serial_oe,
    .rx_reference_clock, .rx_serial_in, .rx_power_down_n, .rx_output_enable,
    .rx_edge_select, .rx_parallel_out, .rx_parallel_oe, .rx_not_aligned,
    .rx_not_aligned_oe, .rx_recovered_clock, .rx_recovered_clock_oe);
  sdr_far_end u_far (.clock, .mode(far_mode), .word(far_word), .serial(rx_serial_in));

  initial forever #20 clock = ~clock;
  initial forever #160 tx_word_clock = ~tx_word_clock;
  initial forever #110 rx_reference_clock = ~rx_reference_clock;

  task finish_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask

  task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Request stands until the edge at which waitrequest is seen low; the watchdog ends a hang
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Pair stays floating for the whole reinitialisation, then comes up
  task tx_init_chk;
    int i;
    for (i = 0; i < 300 && tx_serial_oe !== 1'b1; i++) @(posedge clock);
    chk(i >= (TXI - 1) * 8 && i < 300, 1);
  endtask

  task grab(output logic [35:0] win);
    for (int j = 0; j < 36; j++) begin
      @(posedge clock);
      win[j] = tx_serial_p_o;
    end
  endtask

  function automatic logic has_frame(input logic [35:0] win, input logic [11:0] f);
    for (int k = 0; k < 12; k++) if (win[k+:12] === f && win[k+12+:12] === f) return 1'b1;
    return 1'b0;
  endfunction

  function automatic logic [11:0] exp_frame(input logic [9:0] w);
    return {`SDR_STOP_BIT, w, `SDR_START_BIT};
  endfunction

  initial begin
    int i;
    logic [31:0] q;
    logic [35:0] win;
    logic [9:0]  w;
    void'($urandom(32'hEE2E));
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    tx_init_chk();
    $display("test init done");
    for (int k = 0; k < 2; k++) begin
      {align_request_b, align_request_a} <= k ? 2'b10 : 2'b01;
      tx_parallel_in <= 10'($urandom);
      repeat (40) @(posedge clock);
      grab(win);
      chk(has_frame(win, `SDR_ALIGN_FRAME), 1);
      repeat (1024 * 8) @(posedge clock);
      grab(win);
      chk(has_frame(win, `SDR_ALIGN_FRAME), 1);
    end
    {align_request_b, align_request_a} <= 2'b00;
    $display("test align done");
    for (int k = 0; k < 4; k++) begin
      w = (k == 0) ? 10'h3FF : 10'($urandom);
      tx_parallel_in <= w;
      tx_edge_select <= k[0];
      repeat (60) @(posedge clock);
      grab(win);
      chk(has_frame(win, exp_frame(w)), 1);
    end
    $display("test data done");
    tx_driver_enable <= 1'b0;
    repeat (8) @(posedge clock);
    chk(tx_serial_oe, 0);
    tx_driver_enable <= 1'b1;
    repeat (8) @(posedge clock);
    chk(tx_serial_oe, 1);
    power_down_n <= 1'b0;
    repeat (8) @(posedge clock);
    chk(tx_serial_oe, 0);
    power_down_n <= 1'b1;
    tx_init_chk();
    $display("test enable and powerdown done");
    chk(rx_not_aligned, 1);
    far_mode <= 2'h1;
    for (i = 0; i < 1024 * 12 && rx_not_aligned !== 1'b0; i++) @(posedge clock);
    chk(rx_not_aligned, 0);
    bus(1'b0, `SDR_REG_STATUS, 32'h0, q);
    chk(q[5:0], 6'h28);
    for (int k = 0; k < 2; k++) begin
      w = 10'($urandom);
      far_word <= w;
      far_mode <= 2'h2;
      rx_edge_select <= k[0];
      repeat (60) @(posedge clock);
      chk({rx_parallel_oe, rx_parallel_out}, {1'b1, w});
      // Selected edge of the recovered clock falls half a frame after the word changes
      for (i = 0; i < 12 && rx_recovered_clock !== k[0]; i++) @(posedge clock);
      for (i = 0; i < 12 && rx_recovered_clock !== !k[0]; i++) @(posedge clock);
      for (i = 0; i < 12 && rx_recovered_clock !== k[0]; i++) @(posedge clock);
      chk(i, `SDR_FRAME_BITS / 2);
      bus(1'b0, `SDR_REG_WORD, 32'h0, q);
      chk(q[9:0], w);
    end
    $display("test lock done");
    far_mode <= 2'h3;
    repeat (12) @(posedge clock);
    far_mode <= 2'h2;
    for (i = 0; i < 40 && rx_not_aligned !== 1'b1; i++) @(posedge clock);
    chk({rx_not_aligned, rx_parallel_oe, rx_recovered_clock_oe}, 3'b100);
    bus(1'b0, `SDR_REG_LOSS, 32'h0, q);
    chk(q, 1);
    bus(1'b1, `SDR_REG_CTRL, 32'h2, q);
    bus(1'b0, `SDR_REG_LOSS, 32'h0, q);
    chk(q, 0);
    bus(1'b0, 5'h10, 32'h0, q);
    chk(q, 0);
    $display("test loss done");
    rx_output_enable <= 1'b0;
    rx_power_down_n <= 1'b0;
    repeat (6) @(posedge clock);
    chk({rx_not_aligned_oe, rx_parallel_oe}, 2'b00);
    bus(1'b0, `SDR_REG_STATUS, 32'h0, q);
    chk(q[3:1], 3'h0);
    bus(1'b1, `SDR_REG_CTRL, 32'h1, q);
    repeat (40) @(posedge clock);
    grab(win);
    chk(has_frame(win, `SDR_ALIGN_FRAME), 1);
    $display("test receive disable done");
    finish_test();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_errors++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire

/* hw/sdr_sync.v */
// Two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
`default_nettype none

module sdr_sync #(
  parameter W = 21
) (
  input  wire         clock,
  input  wire         sys_rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // sdr_sync

`default_nettype wire

/* hw/sdr_top.v */
// Serializer and deserializer with embedded clock, Avalon-MM status registers
// Summary of operation
// [RULE_01] Serial output floats while the transmit side acquires the word clock.
// [RULE_02] Alignment request active sends frames of six ones then six zeros.
// [RULE_03] Controlling logic holds an alignment request for at least 1024 word clocks.
// [RULE_04] Alignment frames continue as long as either request stays high.
// [RULE_05] Not-aligned flag high while acquiring reference and pattern, low once locked.
// [RULE_06] Receiver starts hunting for lock after seeing a transition on serial input.
// [RULE_07] Receiver locks to the alignment pattern within 1024 cycles and flags it.
// [RULE_08] Received words are valid only while the not-aligned flag is low.
// [RULE_09] Parallel input captured on rising word clock edge if select high, else falling.
// [RULE_10] After five word clocks of alignment request the parallel input is ignored.
// [RULE_11] Every data frame has start bit one and stop bit zero.
// [RULE_12] Each frame is twelve bits: ten data plus two framing bits.
// [RULE_13] Data sent only with driver enabled, powered up, both requests low.
// [RULE_14] Driver enable low floats the pair; state continues and resumes on return.
// [RULE_15] Lock loss raises the flag and floats received words and recovered clock.
// [RULE_16] System watches the flag and requests at least 1024 alignment frames.
// [RULE_17] Feeding the flag back into an alignment request is recommended.
// [RULE_18] Power-down low (receiver: with output enable low) stops and floats outputs.
// [RULE_19] Transmitter reinitialises for 1024 word clocks; receiver flags until relock.
// [RULE_20] Receiver output enable low floats received words, flag and recovered clock.
// [RULE_21] Received words change relative to the recovered clock edge chosen by select.
// [RULE_22] Frame order: start bit, data bits 0 to 9 ascending, stop bit last.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defines.vh"

module sdr_top #(
  parameter [10:0] TX_INIT_EDGES = `SDR_TX_INIT_EDGES,
  parameter [10:0] REF_EDGES     = `SDR_REF_EDGES,
  parameter [2:0]  LOCK_FRAMES   = `SDR_LOCK_FRAMES,
  parameter        WW            = `SDR_WORD_BITS
) (
  input  wire          clock,
  input  wire          sys_rst,
  input  wire [4:0]    avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  output wire [31:0]   avs_readdata,
  output wire          avs_waitrequest,
  input  wire          tx_word_clock,
  input  wire [WW-1:0] tx_parallel_in,
  input  wire          tx_edge_select,
  input  wire          tx_driver_enable,
  input  wire          power_down_n,
  input  wire          align_request_a,
  input  wire          align_request_b,
  output wire          tx_serial_p_o,
  output wire          tx_serial_n_o,
  output wire          tx_serial_oe,
  input  wire          rx_reference_clock,
  input  wire          rx_serial_in,
  input  wire          rx_power_down_n,
  input  wire          rx_output_enable,
  input  wire          rx_edge_select,
  output wire [WW-1:0] rx_parallel_out,
  output wire          rx_parallel_oe,
  output wire          rx_not_aligned,
  output wire          rx_not_aligned_oe,
  output wire          rx_recovered_clock,
  output wire          rx_recovered_clock_oe
);

  localparam TX_OFF  = 2'h0;
  localparam TX_INIT = 2'h1;
  localparam TX_RUN  = 2'h2;

  localparam RX_OFF  = 3'h0;
  localparam RX_REF  = 3'h1;
  localparam RX_WAIT = 3'h2;
  localparam RX_HUNT = 3'h3;
  localparam RX_LOCK = 3'h4;

  localparam SW = WW + 11;

  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  // All pin inputs except the register bus pass two flops before any logic sees them
  wire [SW-1:0] s;

  sdr_sync #(
    .W (SW)
  ) u_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({rx_serial_in, rx_edge_select, rx_output_enable, rx_power_down_n,
                rx_reference_clock, tx_parallel_in, power_down_n, tx_driver_enable,
                tx_edge_select, align_request_b, align_request_a, tx_word_clock}),
    .sync_out (s)
  );

  wire          s_tx_word_clock   = s[0];
  wire          s_al_a   = s[1];
  wire          s_al_b   = s[2];
  wire          s_tesel  = s[3];
  wire          s_den    = s[4];
  wire          s_pd_n   = s[5];
  wire [WW-1:0] s_din    = s[WW+5:6];
  wire          s_ref    = s[WW+6];
  wire          s_rpd_n  = s[WW+7];
  wire          s_ren    = s[WW+8];
  wire          s_resel  = s[WW+9];
  wire          s_rser   = s[WW+10];

  // Register bus: one wait state on every access
  reg         ack_q;
  reg  [31:0] rdata_q;
  reg         ctrl_fb_q;
  reg  [15:0] loss_q;
  reg  [15:0] loss_d;
  reg  [31:0] rdata_d;
  wire        req = avs_read | avs_write;
  wire        wr_ok = avs_write & ack_q;
  wire        clr_loss = wr_ok && (avs_address == `SDR_REG_CTRL) &&
                         avs_writedata[`SDR_CTRL_CLR_LOSS];

  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;

  // Transmit side
  reg  [1:0]    tx_st_q;
  reg  [1:0]    tx_st_d;
  reg  [10:0]   init_cnt_q;
  reg  [10:0]   init_cnt_d;
  reg  [2:0]    al_cnt_q;
  reg  [WW-1:0] tx_word_q;
  reg           tx_word_clock_prev_q;
  wire          nal_int;
  wire          align_act = s_al_a | s_al_b | (ctrl_fb_q & nal_int);
  wire          tx_word_clock_rise = rise_of(s_tx_word_clock, tx_word_clock_prev_q);
  wire          tx_word_clock_fall = rise_of(tx_word_clock_prev_q, s_tx_word_clock);
  wire          cap_edge  = s_tesel ? tx_word_clock_rise : tx_word_clock_fall; // RULE_09
  wire          al_ignore = (al_cnt_q >= `SDR_ALIGN_IGNORE); // RULE_10
  wire [11:0]   tx_frame;
  wire          frame_take;
  wire          tx_bit;

  // Data frame LSB first: start, data 0..9, stop
  assign tx_frame = align_act ? `SDR_ALIGN_FRAME :  // RULE_02 RULE_04
                    {`SDR_STOP_BIT, tx_word_q, `SDR_START_BIT}; // RULE_11 RULE_13 RULE_22

  always @* begin
    tx_st_d    = tx_st_q;
    init_cnt_d = init_cnt_q;
    case (tx_st_q)
      TX_OFF: begin
        if (s_pd_n) begin
          tx_st_d    = TX_INIT;
          init_cnt_d = 11'h000;
        end
      end
      TX_INIT: begin
        if (tx_word_clock_rise) begin
          init_cnt_d = init_cnt_q + 11'h001;
          if (init_cnt_q == TX_INIT_EDGES - 11'h001) begin
            tx_st_d = TX_RUN; // RULE_19
          end
        end
      end
      TX_RUN: begin
        tx_st_d = TX_RUN;
      end
      default: begin
        tx_st_d = TX_OFF;
      end
    endcase
    if (!s_pd_n) begin
      tx_st_d = TX_OFF; // RULE_18
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      tx_st_q     <= TX_OFF;
      init_cnt_q  <= 11'h000;
      al_cnt_q    <= 3'h0;
      tx_word_q   <= {WW{1'b0}};
      tx_word_clock_prev_q <= 1'b0;
    end else begin
      tx_st_q     <= tx_st_d;
      init_cnt_q  <= init_cnt_d;
      tx_word_clock_prev_q <= s_tx_word_clock;
      if (!align_act) begin
        al_cnt_q <= 3'h0;
      end else if (tx_word_clock_rise && !al_ignore) begin
        al_cnt_q <= al_cnt_q + 3'h1;
      end
      if (tx_st_q == TX_RUN && cap_edge && !al_ignore) begin
        tx_word_q <= s_din; // RULE_09
      end
    end
  end

  sdr_tx_shift #(
    .FW (`SDR_FRAME_BITS)
  ) u_shift (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .run        (tx_st_q == TX_RUN),
    .frame_in   (tx_frame),
    .frame_take (frame_take),
    .bit_out    (tx_bit)
  ); // RULE_12

  // Enable gates only the driver, so the sequence resumes untouched
  assign tx_serial_oe  = (tx_st_q == TX_RUN) & s_den & s_pd_n; // RULE_01 RULE_14 RULE_18
  assign tx_serial_p_o = tx_bit;
  assign tx_serial_n_o = ~tx_bit;

  // Receive side
  reg  [2:0]    rx_st_q;
  reg  [2:0]    rx_st_d;
  reg  [10:0]   ref_cnt_q;
  reg  [3:0]    bit_cnt_q;
  reg  [11:0]   rsh_q;
  reg  [2:0]    good_q;
  reg  [5:0]    idle_q;
  reg           ref_prev_q;
  reg           rser_prev_q;
  reg  [WW-1:0] rx_word_q;
  reg           rclk_q;
  reg           nal_q;
  reg           loss_ev;
  wire [11:0]   rsh_d   = {s_rser, rsh_q[11:1]};
  wire          r_trans = s_rser ^ rser_prev_q;
  wire          r_wrap  = (bit_cnt_q == `SDR_BITCNT_LAST);
  wire          r_ok    = (rsh_d[0] == `SDR_START_BIT) && (rsh_d[11] == `SDR_STOP_BIT);
  wire          r_idle  = (idle_q == `SDR_IDLE_LIMIT);
  wire          r_pdown = ~s_rpd_n & ~s_ren;

  assign nal_int = nal_q;

  always @* begin
    rx_st_d = rx_st_q;
    loss_ev = 1'b0;
    case (rx_st_q)
      RX_OFF: begin
        if (s_rpd_n) begin
          rx_st_d = RX_REF; // RULE_19
        end
      end
      RX_REF: begin
        if (rise_of(s_ref, ref_prev_q) && ref_cnt_q == REF_EDGES - 11'h001) begin
          rx_st_d = RX_WAIT;
        end
      end
      RX_WAIT: begin
        if (r_trans) begin
          rx_st_d = RX_HUNT; // RULE_06
        end
      end
      RX_HUNT: begin
        if (r_idle) begin
          rx_st_d = RX_WAIT;
        end else if (r_wrap && r_ok && good_q == LOCK_FRAMES - 3'h1) begin
          rx_st_d = RX_LOCK; // RULE_07
        end
      end
      RX_LOCK: begin
        if (r_idle || (r_wrap && !r_ok)) begin
          rx_st_d = RX_WAIT;
          loss_ev = 1'b1;
        end
      end
      default: begin
        rx_st_d = RX_OFF;
      end
    endcase
    if (r_pdown) begin
      rx_st_d = RX_OFF; // RULE_18
      loss_ev = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      rx_st_q     <= RX_OFF;
      ref_cnt_q   <= 11'h000;
      bit_cnt_q   <= 4'h0;
      rsh_q       <= 12'h000;
      good_q      <= 3'h0;
      idle_q      <= 6'h00;
      ref_prev_q  <= 1'b0;
      rser_prev_q <= 1'b0;
      rx_word_q   <= {WW{1'b0}};
      rclk_q      <= 1'b0;
      nal_q       <= 1'b1;
    end else begin
      rx_st_q     <= rx_st_d;
      ref_prev_q  <= s_ref;
      rser_prev_q <= s_rser;
      rsh_q       <= rsh_d;
      nal_q       <= (rx_st_d != RX_LOCK); // RULE_05 RULE_15 RULE_19
      if (rx_st_q != RX_REF) begin
        ref_cnt_q <= 11'h000;
      end else if (rise_of(s_ref, ref_prev_q)) begin
        ref_cnt_q <= ref_cnt_q + 11'h001;
      end
      if (r_trans || (rx_st_q != RX_HUNT && rx_st_q != RX_LOCK)) begin
        idle_q <= 6'h00;
      end else if (!r_idle) begin
        idle_q <= idle_q + 6'h01;
      end
      if (rx_st_q != RX_HUNT && rx_st_q != RX_LOCK) begin
        bit_cnt_q <= 4'h0;
        good_q    <= 3'h0;
      end else if (r_wrap) begin
        if (r_ok) begin
          // Frame boundary confirmed: start over on the next twelve bits
          bit_cnt_q <= 4'h0;
          if (good_q != LOCK_FRAMES - 3'h1) begin
            good_q <= good_q + 3'h1;
          end
          if (rx_st_q == RX_LOCK) begin
            rx_word_q <= rsh_d[WW:1]; // RULE_08
          end
        end else begin
          // Slip one bit: stay on the last slot so the next window is tested
          good_q <= 3'h0;
        end
      end else begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
      if (r_wrap) begin
        rclk_q <= ~s_resel; // RULE_21
      end else if (bit_cnt_q == `SDR_RCLK_MID) begin
        rclk_q <= s_resel; // RULE_21
      end
    end
  end

  assign rx_parallel_out       = rx_word_q;
  assign rx_recovered_clock    = rclk_q;
  assign rx_not_aligned        = nal_q;
  assign rx_not_aligned_oe     = s_ren & (rx_st_q != RX_OFF); // RULE_20 RULE_18
  assign rx_parallel_oe        = s_ren & ~nal_q; // RULE_08 RULE_15 RULE_20
  assign rx_recovered_clock_oe = s_ren & ~nal_q; // RULE_15 RULE_20

  // Register file
  always @* begin
    case (avs_address)
      `SDR_REG_CTRL:   rdata_d = {31'h00000000, ctrl_fb_q};
      `SDR_REG_STATUS: rdata_d = {26'h0000000, tx_st_q, rx_st_q, nal_q};
      `SDR_REG_WORD:   rdata_d = {{(32-WW){1'b0}}, rx_word_q};
      `SDR_REG_LOSS:   rdata_d = {16'h0000, loss_q};
      default:         rdata_d = 32'h00000000;
    endcase
    // A lock loss in the clearing cycle still counts
    loss_d = (clr_loss ? 16'h0000 : loss_q) + {15'h0000, loss_ev};
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ack_q     <= 1'b0;
      rdata_q   <= 32'h00000000;
      ctrl_fb_q <= `SDR_CTRL_RESET;
      loss_q    <= 16'h0000;
    end else begin
      ack_q  <= req & ~ack_q;
      loss_q <= loss_d;
      if (avs_read && !ack_q) begin
        rdata_q <= rdata_d;
      end
      if (wr_ok && avs_address == `SDR_REG_CTRL) begin
        ctrl_fb_q <= avs_writedata[`SDR_CTRL_FEEDBACK]; // RULE_17
      end
    end
  end

endmodule // sdr_top

`default_nettype wire

/* hw/sdr_tx_shift.v */
// Frame shifter: sends a 12-bit frame LSB first, one bit per clock
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defines.vh"

module sdr_tx_shift #(
  parameter FW = `SDR_FRAME_BITS
) (
  input  wire          clock,
  input  wire          sys_rst,
  input  wire          run,
  input  wire [FW-1:0] frame_in,
  output wire          frame_take,
  output wire          bit_out
);

  reg [FW-1:0] sh_q;
  reg [3:0]    cnt_q;
  reg          bit_q;

  assign frame_take = run && (cnt_q == `SDR_BITCNT_LAST);
  assign bit_out    = bit_q;

  always @(posedge clock) begin
    if (sys_rst || !run) begin
      // Parked on the last slot so the first cycle of a run loads a frame
      sh_q  <= {FW{1'b0}};
      cnt_q <= `SDR_BITCNT_LAST;
      bit_q <= 1'b0;
    end else if (frame_take) begin
      sh_q  <= {1'b0, frame_in[FW-1:1]};
      bit_q <= frame_in[0];
      cnt_q <= 4'h0;
    end else begin
      sh_q  <= {1'b0, sh_q[FW-1:1]};
      bit_q <= sh_q[0];
      cnt_q <= cnt_q + 4'h1;
    end
  end

endmodule // sdr_tx_shift

`default_nettype wire

/* pkg/sdr_defines.vh */
// Constants shared by the 10-bit embedded-clock serializer and deserializer
`ifndef SDR_DEFINES_VH
`define SDR_DEFINES_VH

`define SDR_WORD_BITS       10
`define SDR_FRAME_BITS      12
`define SDR_BITCNT_LAST     4'hB
`define SDR_RCLK_MID        4'h5
`define SDR_START_BIT       1'b1
`define SDR_STOP_BIT        1'b0
`define SDR_ALIGN_FRAME     12'h03F
`define SDR_TX_INIT_EDGES   11'h400
`define SDR_ALIGN_IGNORE    3'h5
`define SDR_REF_EDGES       11'h010
`define SDR_LOCK_FRAMES     3'h4
`define SDR_IDLE_LIMIT      6'h18

`define SDR_REG_CTRL        5'h00
`define SDR_REG_STATUS      5'h04
`define SDR_REG_WORD        5'h08
`define SDR_REG_LOSS        5'h0C

`define SDR_CTRL_FEEDBACK   0
`define SDR_CTRL_CLR_LOSS   1
`define SDR_CTRL_RESET      1'b0

`endif
